// file: dio_defs.svh
// Offsets, reset values and timing counts of the digital I/O block
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
// Word index on A6..A1 in I/O space
`define OFF_OUT_LO   6'h00
`define OFF_OUT_HI   6'h01
`define OFF_IN_LO    6'h02
`define OFF_IN_HI    6'h03
`define OFF_INT_EN   6'h04
`define OFF_INT_TYPE 6'h05
`define OFF_INT_POL  6'h06
`define OFF_INT_STAT 6'h07
`define OFF_VECTOR   6'h08
`define OUT_RST      32'h0000_0000
`define CFG_RST      8'h00
`define VEC_RST      5'h00
`define WAIT_STATES  2'h1
`define ID_BYTES     8'h0c
`endif

// file: dio_pkg.sv
// Types shared by the digital I/O block
package dio_pkg;
  typedef enum logic [1:0] {bus_idle, bus_wait, bus_ack, bus_hold} bus_state_e;
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] itype;
    logic [7:0] polarity;
    logic [4:0] vector_hi;
  } irq_cfg_s;
endpackage

// file: dio_ctrl.sv
// 32-channel open-drain digital I/O with channel 0-7 interrupts on a local bus
// Functional notes
// - Request line 0 active while any enabled channel interrupt is pending.
// - Acknowledge with A1 high is ignored: no vector, no bus acknowledge.
// - On acknowledge, vector goes on D0-D7 with bus acknowledge asserted.
// - Vector low 3 bits are channel number, upper 5 from vector register.
// - Highest-numbered pending channel presented first, then the next.
// - Only channels 0-7 interrupt, each change-of-state or level match.
// - Type bit 1 selects change-of-state, 0 selects level match.
// - Polarity bit 0 matches low level, 1 matches high level.
// - Request stays until software clears status; acknowledge does not release.
// - Writing 1 to a status bit clears it; writing 0 leaves it.
// - Enable bit 0 blocks a channel's interrupts, 1 allows them.
// - Condition still present after clear raises a new request at once.
// - Output bit 1 closes the low-side switch, 0 opens it.
// - All outputs off after reset.
// - 32 channels, each pin both switch output and input buffer.
// - Input registers read live pin levels, giving output loopback.
// - Channels 0-7 feed interrupt logic; others reach the bus on reads.
// - ID, input and interrupt registers reached over the 16-bit bus.
// - Every decoded access ends with the bus acknowledge.
// - Every access except an acknowledge with A1 high completes with one wait state.
`timescale 1ns/1ps
`include "dio_defs.svh"

module dio_ctrl #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] MODEL_CODE = 8'h11,  // Arbitrary value
  parameter logic [7:0] ID_CRC     = 8'h00   // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        io_sel_n,
  input  wire logic        id_sel_n,
  input  wire logic        int_sel_n,
  input  wire logic        rd_wr,
  input  wire logic [5:0]  addr,
  input  wire logic [1:0]  be_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe_n,
  output logic             ack_n,
  output logic             int_req0_n,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe_n
);
  import dio_pkg::*;

  bus_state_e       state;
  bus_state_e       next_state;
  logic       [1:0]  wait_cnt;
  logic       [1:0]  next_wait_cnt;
  logic              cyc_int;
  logic              next_cyc_int;
  logic       [31:0] out_reg;
  logic       [31:0] next_out_reg;
  irq_cfg_s          cfg;
  irq_cfg_s          next_cfg;
  logic       [15:0] next_data_out;
  logic              next_data_oe_n;
  logic              next_ack_n;
  logic       [7:0]  clr;
  logic       [31:0] pin_meta;
  logic       [31:0] pin_sync;
  logic       [7:0]  prev;
  logic       [7:0]  status;
  logic       [7:0]  next_status;
  logic       [7:0]  cond;
  logic       [7:0]  active;
  logic       [2:0]  top_chan;
  logic              any_sel;

  function automatic logic [2:0] highest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] ben);
    return {ben[1] ? old[15:8] : nw[15:8], ben[0] ? old[7:0] : nw[7:0]};
  endfunction

  function automatic logic [7:0] id_byte(input logic [4:0] idx);
    logic [7:0] b;
    if (idx == 5'h00) begin
      b = 8'h49;
    end else if (idx == 5'h01) begin
      b = 8'h50;
    end else if (idx == 5'h02) begin
      b = 8'h41;
    end else if (idx == 5'h03) begin
      b = 8'h43;
    end else if (idx == 5'h04) begin
      b = MAKER_CODE;
    end else if (idx == 5'h05) begin
      b = MODEL_CODE;
    end else if (idx == 5'h0a) begin
      b = `ID_BYTES;
    end else if (idx == 5'h0b) begin
      b = ID_CRC;
    end else begin
      b = 8'h00;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt detection and status

  // Enabled pending channels decide both the request and the vector
  assign active   = status & cfg.enable;
  assign top_chan = highest(active);

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Successive samples differ, or sample equals chosen level
      cond[i] = cfg.itype[i] ? (pin_sync[i] != prev[i]) : (pin_sync[i] == cfg.polarity[i]);
    end
    // Set beats clear so a lasting condition re-raises at once
    next_status = (status & ~clr) | (cond & cfg.enable);
  end

  always_ff @(posedge clk) begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
    // Tracks the pin through reset so that release brings no false change
    prev     <= pin_sync[7:0];
    if (reset) begin
      status     <= 8'h00;
      int_req0_n <= 1'b1;
    end else begin
      status     <= next_status;
      int_req0_n <= ~|active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local bus slave and registers

  assign any_sel = ~io_sel_n | ~id_sel_n | ~int_sel_n;

  always_comb begin
    next_state     = state;
    next_wait_cnt  = wait_cnt;
    next_cyc_int   = cyc_int;
    next_out_reg   = out_reg;
    next_cfg       = cfg;
    next_data_out  = data_out;
    next_data_oe_n = 1'b1;
    next_ack_n     = 1'b1;
    clr            = 8'h00;
    case (state)
      bus_idle: begin
        if (!int_sel_n && addr[0]) begin
          next_state = bus_hold;
        end else if (any_sel) begin
          next_state    = bus_wait;
          next_wait_cnt = `WAIT_STATES;
          next_cyc_int  = ~int_sel_n;
        end
      end
      bus_wait: begin
        if (wait_cnt > 2'h1) begin
          next_wait_cnt = wait_cnt - 2'h1;
        end else begin
          next_state = bus_ack;
          next_ack_n = 1'b0;
          if (cyc_int) begin
            // Acknowledge leaves status alone; only a write releases
            next_data_out  = {8'h00, cfg.vector_hi, top_chan};
            next_data_oe_n = 1'b0;
          end else if (!id_sel_n) begin
            next_data_out  = {8'h00, id_byte(addr[4:0])};
            next_data_oe_n = ~rd_wr;
          end else if (rd_wr) begin
            next_data_oe_n = 1'b0;
            if (addr == `OFF_OUT_LO) begin
              next_data_out = out_reg[15:0];
            end else if (addr == `OFF_OUT_HI) begin
              next_data_out = out_reg[31:16];
            end else if (addr == `OFF_IN_LO) begin
              next_data_out = pin_sync[15:0];
            end else if (addr == `OFF_IN_HI) begin
              next_data_out = pin_sync[31:16];
            end else if (addr == `OFF_INT_EN) begin
              next_data_out = {8'h00, cfg.enable};
            end else if (addr == `OFF_INT_TYPE) begin
              next_data_out = {8'h00, cfg.itype};
            end else if (addr == `OFF_INT_POL) begin
              next_data_out = {8'h00, cfg.polarity};
            end else if (addr == `OFF_INT_STAT) begin
              next_data_out = {8'h00, status};
            end else if (addr == `OFF_VECTOR) begin
              next_data_out = {8'h00, cfg.vector_hi, 3'h0};
            end else begin
              next_data_out = 16'h0000;
            end
          end else begin
            if (addr == `OFF_OUT_LO) begin
              next_out_reg[15:0] = merge(out_reg[15:0], data_in, be_n);
            end else if (addr == `OFF_OUT_HI) begin
              next_out_reg[31:16] = merge(out_reg[31:16], data_in, be_n);
            end else if (addr == `OFF_INT_EN && !be_n[0]) begin
              next_cfg.enable = data_in[7:0];
            end else if (addr == `OFF_INT_TYPE && !be_n[0]) begin
              next_cfg.itype = data_in[7:0];
            end else if (addr == `OFF_INT_POL && !be_n[0]) begin
              next_cfg.polarity = data_in[7:0];
            end else if (addr == `OFF_INT_STAT && !be_n[0]) begin
              clr = data_in[7:0];
            end else if (addr == `OFF_VECTOR && !be_n[0]) begin
              next_cfg.vector_hi = data_in[7:3];
            end
          end
        end
      end
      bus_ack: begin
        next_state = bus_hold;
      end
      default: begin
        if (!any_sel) begin
          next_state = bus_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= bus_idle;
      wait_cnt  <= 2'h0;
      cyc_int   <= 1'b0;
      out_reg   <= `OUT_RST;
      cfg       <= '{`CFG_RST, `CFG_RST, `CFG_RST, `VEC_RST};
      data_out  <= 16'h0000;
      data_oe_n <= 1'b1;
      ack_n     <= 1'b1;
      pin_out   <= 32'h0000_0000;
      pin_oe_n  <= 32'hffff_ffff;
    end else begin
      state     <= next_state;
      wait_cnt  <= next_wait_cnt;
      cyc_int   <= next_cyc_int;
      out_reg   <= next_out_reg;
      cfg       <= next_cfg;
      data_out  <= next_data_out;
      data_oe_n <= next_data_oe_n;
      ack_n     <= next_ack_n;
      pin_out   <= 32'h0000_0000;
      // Switch closed pulls the pin low; pin still readable as input
      pin_oe_n  <= ~out_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_taken;
    state == bus_idle && any_sel && !(!int_sel_n && addr[0]);
  endsequence

  sequence s_one_wait;
    ##1 ack_n ##1 !ack_n ##1 ack_n;
  endsequence

  property p_access_ack;
    @(posedge clk) disable iff (reset) s_taken |-> s_one_wait;
  endproperty
  a_access_ack: assert property (p_access_ack) else $error("access not acked after one wait state");

  property p_req;
    @(posedge clk) disable iff (reset) (|active) |=> !int_req0_n;
  endproperty
  a_req: assert property (p_req) else $error("pending interrupt without request");

  property p_a1_high;
    @(posedge clk) disable iff (reset)
      (state == bus_idle && !int_sel_n && addr[0]) |=> (ack_n && data_oe_n) [*3];
  endproperty
  a_a1_high: assert property (p_a1_high) else $error("answered acknowledge for line 1");

  property p_vector;
    @(posedge clk) disable iff (reset)
      (state == bus_wait && cyc_int && wait_cnt == 2'h1)
        |=> (!ack_n && !data_oe_n && data_out[7:0] == {cfg.vector_hi, $past(top_chan)});
  endproperty
  a_vector: assert property (p_vector) else $error("wrong interrupt vector");

  property p_hold;
    @(posedge clk) disable iff (reset)
      1'b1 |=> ((status & $past(status & ~clr)) == $past(status & ~clr));
  endproperty
  a_hold: assert property (p_hold) else $error("status dropped without clear");

  property p_blocked;
    @(posedge clk) disable iff (reset)
      1'b1 |=> ((status & ~$past(status) & ~$past(cfg.enable)) == 8'h00);
  endproperty
  a_blocked: assert property (p_blocked) else $error("disabled channel became pending");

  property p_reraise;
    @(posedge clk) disable iff (reset)
      (|(clr & cond & cfg.enable)) |=> (|status) ##1 !int_req0_n;
  endproperty
  a_reraise: assert property (p_reraise) else $error("held condition not re-raised");

  property p_out_off;
    @(posedge clk) reset |=> (pin_oe_n == 32'hffff_ffff && out_reg == 32'h0000_0000);
  endproperty
  a_out_off: assert property (p_out_off) else $error("output on after reset");

  property p_switch;
    @(posedge clk) disable iff (reset) 1'b1 |=> (pin_oe_n == ~$past(out_reg));
  endproperty
  a_switch: assert property (p_switch) else $error("switch state differs from output bit");
endmodule

// file: dio_carrier.sv
// Carrier model that drives the module's local bus
`timescale 1ns/1ps
module dio_carrier (
  input  wire logic        clk,
  output logic             io_sel_n,
  output logic             id_sel_n,
  output logic             int_sel_n,
  output logic             rd_wr,
  output logic [5:0]       addr,
  output logic [1:0]       be_n,
  output logic [15:0]      data_in,
  input  wire logic        ack_n,
  input  wire logic        data_oe_n,
  input  wire logic [15:0] data_out
);
  initial begin
    {io_sel_n, id_sel_n, int_sel_n, rd_wr} = 4'hf;
    addr = 6'h00;
    be_n = 2'h3;
    data_in = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Kind 0 I/O, 1 ID, 2 acknowledge, 3 I/O upper byte only; n is the edge that saw ack, 0 if none
  task automatic xfer(input int kind, input logic wr, input logic [5:0] a, input logic [15:0] d,
                      output logic [15:0] q, output int n, output logic oe);
    n = 0;
    q = 16'h0000;
    oe = 1'b1;
    @(posedge clk);
    #1;
    rd_wr = !wr;
    addr = a;
    be_n = (kind == 3) ? 2'h1 : 2'h0;
    data_in = d;
    io_sel_n = (kind != 0 && kind != 3);
    id_sel_n = (kind != 1);
    int_sel_n = (kind != 2);
    for (int i = 1; i <= 6 && n == 0; i++) begin
      @(posedge clk);
      if (ack_n === 1'b0) begin
        n = i;
        q = data_out;
        oe = data_oe_n;
      end
    end
    #1;
    {io_sel_n, id_sel_n, int_sel_n} = 3'h7;
    be_n = 2'h3;
    // Released bus must not look like the last value
    data_in = ~d;
    @(posedge clk);
  endtask
endmodule

// file: tb_dio_ctrl.sv
// Self-checking testbench for the digital I/O block
`timescale 1ns/1ps
`include "dio_defs.svh"
module tb_dio_ctrl;
  // Taking edge is 1, ack registered at 2 after one wait state, seen at 3
  localparam int ACK_EDGE = 3;
  logic        clk;
  logic        reset;
  logic        io_sel_n;
  logic        id_sel_n;
  logic        int_sel_n;
  logic        rd_wr;
  logic        data_oe_n;
  logic        ack_n;
  logic        int_req0_n;
  logic [5:0]  addr;
  logic [1:0]  be_n;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic [15:0] q;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic [31:0] field;
  int          n_mismatch = 0;
  int          tests_run = 0;
  // Field wiring pulls up; a closed switch pulls the pin low
  assign pin_in = field & pin_oe_n;
  dio_ctrl DUT (.clk(clk), .reset(reset), .io_sel_n(io_sel_n), .id_sel_n(id_sel_n),
    .int_sel_n(int_sel_n), .rd_wr(rd_wr), .addr(addr), .be_n(be_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .ack_n(ack_n), .int_req0_n(int_req0_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  dio_carrier u_car (.clk(clk), .io_sel_n(io_sel_n), .id_sel_n(id_sel_n), .int_sel_n(int_sel_n),
    .rd_wr(rd_wr), .addr(addr), .be_n(be_n), .data_in(data_in), .ack_n(ack_n), .data_oe_n(data_oe_n),
    .data_out(data_out));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input int kind, input logic wr, input logic [5:0] a, input logic [15:0] d, input int en);
    int n;
    logic oe;
    u_car.xfer(kind, wr, a, d, q, n, oe);
    check("ack edge", n, en);
    check("data drive", oe, wr || en == 0);
    if (en != 0 && n == 0) final_report;
  endtask
  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 12 && int_req0_n !== lvl; i++) @(posedge clk);
    check("irq", int_req0_n, lvl);
    if (int_req0_n !== lvl) final_report;
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    field = 32'hffff_ffff;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    check("oe", pin_oe_n, 32'hffff_ffff);
    check("req", int_req0_n, 1'b1);
    acc(0, 1'b1, `OFF_OUT_LO, 16'h1234, ACK_EDGE);
    acc(0, 1'b1, `OFF_OUT_HI, 16'h8001, ACK_EDGE);
    check("oe", pin_oe_n, ~32'h8001_1234);
    check("pin out", pin_out, 32'h0000_0000);
    acc(0, 1'b0, `OFF_IN_LO, 16'h0000, ACK_EDGE);
    check("in lo", q, 32'h0000_edcb);
    acc(0, 1'b0, `OFF_IN_HI, 16'h0000, ACK_EDGE);
    check("in hi", q, 32'h0000_7ffe);
    acc(3, 1'b1, `OFF_OUT_LO, 16'h5600, ACK_EDGE);
    acc(0, 1'b0, `OFF_OUT_LO, 16'h0000, ACK_EDGE);
    check("out lo", q, 32'h0000_5634);
    acc(1, 1'b0, 6'h00, 16'h0000, ACK_EDGE);
    check("id", q[7:0], 8'h49);
    acc(1, 1'b0, 6'h0a, 16'h0000, ACK_EDGE);
    check("id", q[7:0], `ID_BYTES);
    acc(0, 1'b1, `OFF_OUT_LO, 16'h0000, ACK_EDGE);
    acc(0, 1'b1, `OFF_VECTOR, 16'h00a8, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_POL, 16'h00ff, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_EN, 16'h0024, ACK_EDGE);
    wait_irq(1'b0);
    acc(2, 1'b0, 6'h01, 16'h0000, 0);
    acc(2, 1'b0, 6'h00, 16'h0000, ACK_EDGE);
    check("vector", q[7:0], 8'had);
    acc(0, 1'b0, `OFF_INT_STAT, 16'h0000, ACK_EDGE);
    check("status", q, 32'h0000_0024);
    acc(0, 1'b0, `OFF_VECTOR, 16'h0000, ACK_EDGE);
    check("vector reg", q, 32'h0000_00a8);
    check("req", int_req0_n, 1'b0);
    #1 field[5] = 1'b0;
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0000, ACK_EDGE);
    acc(2, 1'b0, 6'h00, 16'h0000, ACK_EDGE);
    check("vector", q[7:0], 8'had);
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0020, ACK_EDGE);
    acc(2, 1'b0, 6'h00, 16'h0000, ACK_EDGE);
    check("vector", q[7:0], 8'haa);
    // Handler order: disable, clear, re-enable while the level still holds
    acc(0, 1'b1, `OFF_INT_EN, 16'h0000, ACK_EDGE);
    wait_irq(1'b1);
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0004, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_EN, 16'h0004, ACK_EDGE);
    wait_irq(1'b0);
    // Clear while enabled and still matched: set wins, request stays
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0004, ACK_EDGE);
    check("req", int_req0_n, 1'b0);
    acc(0, 1'b1, `OFF_INT_POL, 16'h0000, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0004, ACK_EDGE);
    wait_irq(1'b1);
    acc(0, 1'b1, `OFF_INT_EN, 16'h0000, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_TYPE, 16'h0080, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_STAT, 16'h00ff, ACK_EDGE);
    acc(0, 1'b1, `OFF_INT_EN, 16'h0080, ACK_EDGE);
    repeat (8) @(posedge clk);
    check("req", int_req0_n, 1'b1);
    #1 field[7] = 1'b0;
    wait_irq(1'b0);
    acc(2, 1'b0, 6'h00, 16'h0000, ACK_EDGE);
    check("vector", q[7:0], 8'haf);
    acc(0, 1'b1, `OFF_INT_STAT, 16'h0080, ACK_EDGE);
    repeat (8) @(posedge clk);
    check("req", int_req0_n, 1'b1);
    // A system reset in mid-run must switch every output off again
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    check("oe", pin_oe_n, 32'hffff_ffff);
    acc(0, 1'b0, `OFF_OUT_HI, 16'h0000, ACK_EDGE);
    check("out hi", q, 32'h0000_0000);
    final_report;
  end
endmodule
